// File: hdl/pom_defines.svh
// constants for the output macrocell array: offsets, fields, resets
// assumes a single 40 MHz system clock and an APB register port
`ifndef POM_DEFINES_SVH
`define POM_DEFINES_SVH

`define POM_NUM_CELLS 8
`define POM_NUM_PT 8
`define POM_NUM_DIN 12
`define POM_ADDR_W 12

`define POM_OFS_CTRL 12'h000
`define POM_OFS_POL 12'h004
`define POM_OFS_IOCFG 12'h008
`define POM_OFS_PINS 12'h00C
`define POM_OFS_INPUTS 12'h010
`define POM_OFS_REGQ 12'h014
`define POM_PT_REGION 3'h1

`define POM_CTRL_ARCH_BIT 0
`define POM_CTRL_SYNC_BIT 1
`define POM_PT_EN_BIT 31

`define POM_RST_CTRL 2'h0
`define POM_RST_POL 8'h00
`define POM_RST_IOCFG 8'h00

`define POM_OUTER_LO 0
`define POM_OUTER_HI 7
`define POM_CENTER_LO 3
`define POM_CENTER_HI 4

`endif

// File: hdl/pom_macrocell.sv
// one output macrocell: product-term sums, register, enable, polarity
// assumes synchronised pin inputs and a one-cycle common clock enable
`timescale 1ns/1ps
`default_nettype none
module pom_macrocell #(
	parameter bit IS_CENTER = 1'b0,
	parameter int NPT = 8
)(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire pom_pkg::pom_mode_t i_mode,
	input wire pom_pkg::pom_cell_cfg_t i_cfg,
	input wire logic [NPT-1:0] i_pt,
	input wire logic i_clk_en,
	input wire logic i_oe_n,
	input wire logic i_pin_s,
	output logic o_pin,
	output logic o_oe_n,
	output logic o_fb,
	output logic o_q
);
	import pom_pkg::*;

	logic q_r;
	logic q_nxt;
	logic pin_r;
	logic oe_n_r;
	logic sum_all;
	logic sum_io;
	logic pt_oe;
	logic is_reg;
	logic val;
	logic drive;

	assign sum_all = |i_pt;
	assign sum_io = |i_pt[NPT-1:1];
	assign pt_oe = i_pt[0];
	assign is_reg = (i_mode == POM_MODE_REG) & ~i_cfg.io_cfg;
	assign q_nxt = i_clk_en ? sum_all : q_r;

	always_comb
	begin
		val = sum_io;
		drive = pt_oe;
		case (i_mode)
			POM_MODE_REG:
			begin
				if (is_reg)
				begin
					val = q_r;
					drive = ~i_oe_n;
				end
			end
			POM_MODE_CPLX:
			begin
				val = sum_io;
				drive = pt_oe;
			end
			POM_MODE_SMPL:
			begin
				val = sum_all;
				drive = IS_CENTER | ~i_cfg.io_cfg;
			end
			default:
			begin
				val = 1'b0;
				drive = 1'b0;
			end
		endcase
	end

	// pins are registered so no combinational loop forms through the pads
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			q_r <= 1'b0;
			pin_r <= 1'b0;
			oe_n_r <= 1'b1;
		end
		else
		begin
			q_r <= q_nxt;
			pin_r <= val ^ i_cfg.pol;
			oe_n_r <= ~drive;
		end
	end

	assign o_pin = pin_r;
	assign o_oe_n = oe_n_r;
	assign o_fb = is_reg ? q_r : i_pin_s;
	assign o_q = q_r;
endmodule // pom_macrocell
`default_nettype wire

// File: hdl/pom_pkg.sv
// types shared by the macrocell array and its cells
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package pom_pkg;

	typedef enum logic [1:0]
	{
		POM_MODE_REG = 2'b00,
		POM_MODE_CPLX = 2'b01,
		POM_MODE_SMPL = 2'b11
	} pom_mode_t;

	typedef struct packed
	{
		logic pol;
		logic io_cfg;
	} pom_cell_cfg_t;

endpackage
`default_nettype wire

// File: hdl/pom_sync2.sv
// two-flop synchroniser for pin levels
// assumes inputs are asynchronous levels, held at least two clock cycles
`timescale 1ns/1ps
`default_nettype none
module pom_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
)(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	// first stage is read only by the second
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			meta_r <= RST_VAL;
			q_r <= RST_VAL;
		end
		else
		begin
			meta_r <= i_d;
			q_r <= meta_r;
		end
	end

	assign o_q = q_r;
endmodule // pom_sync2
`default_nettype wire

// File: hdl/pom_top.sv
// macrocell array top: APB registers, term store, AND array, routing
// assumes pins are asynchronous to I_SYS_CLK and an APB master on I_SYS_CLK
`timescale 1ns/1ps
`default_nettype none
`include "pom_defines.svh"
module pom_top #(
	parameter int NUM_DIN = `POM_NUM_DIN
)(
	input wire logic I_SYS_CLK,
	input wire logic I_RST,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [`POM_ADDR_W-1:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic [NUM_DIN-1:0] I_DIN,
	input wire logic I_CLK_PIN,
	input wire logic I_OE_N_PIN,
	input wire logic [`POM_NUM_CELLS-1:0] I_CELL_PIN,
	output logic [`POM_NUM_CELLS-1:0] O_CELL_PIN,
	output logic [`POM_NUM_CELLS-1:0] O_CELL_PIN_OE_N
);
	import pom_pkg::*;

	localparam int NC = `POM_NUM_CELLS;
	localparam int NPT = `POM_NUM_PT;
	localparam int NT = NC * NPT;
	localparam int PTW = $clog2(NT);
	// term masks share a word with the enable bit, so at most 31 columns
	localparam int NCOL = NUM_DIN + NC;
	localparam int NSYNC = NUM_DIN + 2 + NC;
	localparam logic [NSYNC-1:0] SYNC_RST = {1'b1, {(NSYNC-1){1'b0}}};

	////////////////////////////////////////////////////////////////////
	// pin synchronisers and common clock edge

	logic [NSYNC-1:0] pins_raw;
	logic [NSYNC-1:0] pins_s;
	logic [NC-1:0] cell_pin_s;
	logic [NUM_DIN-1:0] din_s;
	logic clk_pin_s;
	logic oe_n_s;
	logic clk_pin_d_r;
	logic clk_rise;

	// pads come back through the same synchroniser, so a cell that
	// drives its own pad sees that level two cycles later
	assign pins_raw = {I_OE_N_PIN, I_CLK_PIN, I_DIN, I_CELL_PIN};

	// enable pin idles high, so reset leaves registered outputs off
	pom_sync2 #(
		.W(NSYNC),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.i_clk(I_SYS_CLK),
		.i_rst(I_RST),
		.i_d(pins_raw),
		.o_q(pins_s)
	);

	assign cell_pin_s = pins_s[NC-1:0];
	assign din_s = pins_s[NC+NUM_DIN-1:NC];
	assign clk_pin_s = pins_s[NSYNC-2];
	assign oe_n_s = pins_s[NSYNC-1];

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
			clk_pin_d_r <= 1'b0;
		else
			clk_pin_d_r <= clk_pin_s;
	end

	// common clock pin sampled: high phase must span two system cycles
	// outside registered mode a rise still loads registers only the 0x014 word reads
	assign clk_rise = clk_pin_s & ~clk_pin_d_r;

	////////////////////////////////////////////////////////////////////
	// APB decode
	// 0x000 mode word: bit 1 sync, bit 0 arch; sync low selects registered
	// 0x004 per-cell polarity: a set bit inverts that cell's output
	// 0x008 per-cell config: register or I/O, or input or output in simple
	// 0x00C pin status, 0x010 synchronised inputs, 0x014 register bits
	// 0x200 + 8*t: term t, enable and true mask, then complement mask
	// unmapped accesses and writes to status words answer with an error

	logic apb_setup;
	logic apb_access;
	logic apb_wr;
	logic aligned;
	logic hit_ctrl;
	logic hit_pol;
	logic hit_io;
	logic hit_pins;
	logic hit_inputs;
	logic hit_regq;
	logic hit_pt;
	logic hit_ro;
	logic addr_hit;
	logic wr_err;
	logic [PTW-1:0] pt_idx;
	logic pt_hi;
	logic wr_ctrl;
	logic wr_pol;
	logic wr_io;
	logic wr_pt_true;
	logic wr_pt_comp;
	logic rd_capture;

	assign apb_setup = I_PSEL & ~I_PENABLE;
	assign apb_access = I_PSEL & I_PENABLE;
	assign apb_wr = apb_access & I_PWRITE & addr_hit & ~wr_err;
	assign aligned = (I_PADDR[1:0] == 2'b00);
	assign hit_ctrl = (I_PADDR == `POM_OFS_CTRL);
	assign hit_pol = (I_PADDR == `POM_OFS_POL);
	assign hit_io = (I_PADDR == `POM_OFS_IOCFG);
	assign hit_pins = (I_PADDR == `POM_OFS_PINS);
	assign hit_inputs = (I_PADDR == `POM_OFS_INPUTS);
	assign hit_regq = (I_PADDR == `POM_OFS_REGQ);
	assign hit_pt = aligned & (I_PADDR[11:9] == `POM_PT_REGION);
	assign hit_ro = hit_pins | hit_inputs | hit_regq;
	assign addr_hit = hit_ctrl | hit_pol | hit_io | hit_pt | hit_ro;
	assign wr_err = I_PWRITE & hit_ro;
	assign pt_idx = I_PADDR[PTW+2:3];
	assign pt_hi = I_PADDR[2];

	// one strobe per target keeps the register processes short
	assign wr_ctrl = apb_wr & hit_ctrl;
	assign wr_pol = apb_wr & hit_pol;
	assign wr_io = apb_wr & hit_io;
	assign wr_pt_true = apb_wr & hit_pt & ~pt_hi;
	assign wr_pt_comp = apb_wr & hit_pt & pt_hi;
	// read data is taken in setup so it stands for the whole access cycle
	assign rd_capture = apb_setup & ~I_PWRITE;

	////////////////////////////////////////////////////////////////////
	// configuration registers

	logic [1:0] ctrl_r;
	logic [NC-1:0] pol_r;
	logic [NC-1:0] io_r;

	// reset leaves registered mode, register cells and no inversion
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			ctrl_r <= `POM_RST_CTRL;
			pol_r <= `POM_RST_POL;
			io_r <= `POM_RST_IOCFG;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= I_PWDATA[1:0];
			if (wr_pol)
				pol_r <= I_PWDATA[NC-1:0];
			if (wr_io)
				io_r <= I_PWDATA[NC-1:0];
		end
	end

	logic sync_bit;
	logic arch_bit;
	pom_mode_t mode;

	assign sync_bit = ctrl_r[`POM_CTRL_SYNC_BIT];
	assign arch_bit = ctrl_r[`POM_CTRL_ARCH_BIT];
	assign mode = !sync_bit ? POM_MODE_REG :
		(arch_bit ? POM_MODE_CPLX : POM_MODE_SMPL);

	////////////////////////////////////////////////////////////////////
	// product-term store: true mask, complement mask, enable

	logic [NCOL-1:0] pt_true_mem [NT];
	logic [NCOL-1:0] pt_comp_mem [NT];
	logic [NT-1:0] pt_en_r;

	// masks need no reset: a disabled term reads as zero whatever they hold
	always_ff @(posedge I_SYS_CLK)
	begin
		if (wr_pt_true)
			pt_true_mem[pt_idx] <= I_PWDATA[NCOL-1:0];
		if (wr_pt_comp)
			pt_comp_mem[pt_idx] <= I_PWDATA[NCOL-1:0];
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
			pt_en_r <= '0;
		else if (wr_pt_true)
			pt_en_r[pt_idx] <= I_PWDATA[`POM_PT_EN_BIT];
	end

	////////////////////////////////////////////////////////////////////
	// feedback routing into the array

	logic [NC-1:0] cell_fb;
	logic [NC-1:0] fb_col;
	logic [NC-1:0] cell_q;
	logic [NC-1:0] cell_pin;
	logic [NC-1:0] cell_oe_n;
	logic [NCOL-1:0] col_vec;
	logic mode_reg;
	logic mode_smpl;

	// registered: column k is cell k's own feedback
	// complex: columns 0 and 7 carry the clock and enable pins instead
	// simple: those two as well, and the others read a neighbouring pad
	assign mode_reg = (mode == POM_MODE_REG);
	assign mode_smpl = (mode == POM_MODE_SMPL);

	genvar k;
	generate
		for (k = 0; k < NC; k++)
		begin : g_col
			if (k == `POM_OUTER_LO)
			begin : g_lo
				// clock pin takes over this column outside registered mode
				assign fb_col[k] = mode_reg ?
					cell_fb[k] : clk_pin_s;
			end
			else if (k == `POM_OUTER_HI)
			begin : g_hi
				assign fb_col[k] = mode_reg ?
					cell_fb[k] : oe_n_s;
			end
			else
			begin : g_mid
				// centre pins are never read back in simple mode
				localparam int NB = (k <= `POM_CENTER_LO) ? k - 1 : k + 1;
				assign fb_col[k] = mode_smpl ?
					cell_pin_s[NB] : cell_fb[k];
			end
		end
	endgenerate

	assign col_vec = {fb_col, din_s};

	////////////////////////////////////////////////////////////////////
	// AND array

	// data inputs in the low columns, feedback above; an enabled term
	// with no mask bit set is constant true, handy as an always-on enable
	logic [NT-1:0] pt_val;

	genvar t;
	generate
		for (t = 0; t < NT; t++)
		begin : g_pt
			assign pt_val[t] = pt_en_r[t] &
				(&(col_vec | ~pt_true_mem[t])) &
				(&(~col_vec | ~pt_comp_mem[t]));
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// macrocells
	// each cell owns eight terms in a row; its first is the enable term in complex mode and for I/O cells in registered mode

	generate
		for (k = 0; k < NC; k++)
		begin : g_cell
			pom_cell_cfg_t cfg;
			assign cfg.pol = pol_r[k];
			// outer cells in complex mode keep outputs; their column is gone
			assign cfg.io_cfg = io_r[k];
			pom_macrocell #(
				.IS_CENTER((k == `POM_CENTER_LO) || (k == `POM_CENTER_HI)),
				.NPT(NPT)
			) u_cell (
				.i_clk(I_SYS_CLK),
				.i_rst(I_RST),
				.i_mode(mode),
				.i_cfg(cfg),
				.i_pt(pt_val[k*NPT +: NPT]),
				.i_clk_en(clk_rise),
				.i_oe_n(oe_n_s),
				.i_pin_s(cell_pin_s[k]),
				.o_pin(cell_pin[k]),
				.o_oe_n(cell_oe_n[k]),
				.o_fb(cell_fb[k]),
				.o_q(cell_q[k])
			);
		end
	endgenerate

	assign O_CELL_PIN = cell_pin;
	assign O_CELL_PIN_OE_N = cell_oe_n;

	////////////////////////////////////////////////////////////////////
	// read path: data captured in the setup phase, zero wait states

	logic [31:0] ctrl_rd;
	logic [31:0] pol_rd;
	logic [31:0] io_rd;
	logic [31:0] pins_rd;
	logic [31:0] inputs_rd;
	logic [31:0] regq_rd;
	logic [31:0] pt_lo_rd;
	logic [31:0] pt_hi_rd;
	logic [31:0] rd_mux;
	logic [31:0] prdata_r;

	assign ctrl_rd = 32'(ctrl_r);
	assign pol_rd = 32'(pol_r);
	assign io_rd = 32'(io_r);
	// status words: enables above values; enable pin, clock pin, data
	// inputs and pads, all as the array sees them after synchronising
	assign pins_rd = 32'({cell_oe_n, cell_pin});
	assign inputs_rd = 32'(pins_s);
	assign regq_rd = 32'(cell_q);
	assign pt_lo_rd = 32'(pt_true_mem[pt_idx]) |
		{pt_en_r[pt_idx], 31'h0000_0000};
	assign pt_hi_rd = 32'(pt_comp_mem[pt_idx]);

	assign rd_mux = hit_ctrl ? ctrl_rd :
		hit_pol ? pol_rd :
		hit_io ? io_rd :
		hit_pins ? pins_rd :
		hit_inputs ? inputs_rd :
		hit_regq ? regq_rd :
		(hit_pt && pt_hi) ? pt_hi_rd :
		hit_pt ? pt_lo_rd :
		32'h0000_0000;

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
			prdata_r <= 32'h0000_0000;
		else if (rd_capture)
			prdata_r <= rd_mux;
	end

	assign O_PRDATA = prdata_r;
	assign O_PREADY = 1'b1;
	// unmapped address or write to a status word
	assign O_PSLVERR = apb_access & (~addr_hit | wr_err);
endmodule // pom_top
`default_nettype wire

// File: test/pom_board.sv
// board beside the array: resolves each cell pad from both drivers
// assumes the bench drives a pad only while the cell releases it
`timescale 1ns/1ps
`default_nettype none
module pom_board (
	input wire logic [7:0] i_drv_en,
	input wire logic [7:0] i_drv_val,
	input wire logic [7:0] i_pin,
	input wire logic [7:0] i_pin_oe_n,
	output logic [7:0] o_pad
);
	// released pads go to the pull-up, never hold the last value
	always_comb
		for (int i = 0; i < 8; i++)
			o_pad[i] = !i_pin_oe_n[i] ? i_pin[i] : (i_drv_en[i] ? i_drv_val[i] : 1'b1);
endmodule // pom_board
`default_nettype wire

// File: test/pom_top_monitor.sv
// checker for the macrocell array top: apb replies and pin drive relations
// assumes a bind onto pom_top; it tracks the config words from apb writes
`timescale 1ns/1ps
`default_nettype none
module pom_top_monitor (
	input wire logic I_SYS_CLK,
	input wire logic I_RST,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic O_PREADY,
	input wire logic O_PSLVERR,
	input wire logic I_CLK_PIN,
	input wire logic I_OE_N_PIN,
	input wire logic [7:0] O_CELL_PIN,
	input wire logic [7:0] O_CELL_PIN_OE_N
);
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RST);
	logic [1:0] ctrl_r;
	logic [7:0] pol_r;
	logic [7:0] io_r;
	logic [3:0] age_r;
	wire wr = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
	wire pol_wr = wr && (I_PADDR == 12'h004);
	wire cfg_wr = wr && (I_PADDR < 12'h00C) && (I_PADDR[1:0] == 2'h0);
	wire reg_m = !ctrl_r[1];
	wire smpl_m = (ctrl_r == 2'h2);
	// outputs lag config by a few cycles, so relations wait for it to settle
	wire settled = (age_r > 4'h7);
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			ctrl_r <= 2'h0;
			pol_r <= 8'h00;
			io_r <= 8'h00;
		end
		else if (wr && I_PADDR == 12'h000)
			ctrl_r <= I_PWDATA[1:0];
		else if (pol_wr)
			pol_r <= I_PWDATA[7:0];
		else if (wr && I_PADDR == 12'h008)
			io_r <= I_PWDATA[7:0];
	end
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST || cfg_wr)
			age_r <= 4'h0;
		else if (age_r != 4'hF)
			age_r <= age_r + 4'h1;
	end
	////////////////////////////////////////////////////////////////////////
	sequence oe_low_s;
		(!I_OE_N_PIN)[*5];
	endsequence
	sequence oe_high_s;
		I_OE_N_PIN[*5];
	endsequence
	sequence clk_low_s;
		(!I_CLK_PIN)[*5];
	endsequence
	pready_on_a: assert property (O_PREADY)
		else $error("pready low");
	err_phase_a: assert property (!(I_PSEL && I_PENABLE) |-> !O_PSLVERR)
		else $error("pslverr outside access");
	ro_write_a: assert property (wr && I_PADDR == 12'h00C |-> O_PSLVERR)
		else $error("status write not refused");
	reset_idle_a: assert property ($fell(I_RST) |-> O_CELL_PIN_OE_N == 8'hFF)
		else $error("pins driven out of reset");
	reg_drive_a: assert property (oe_low_s ##0 reg_m && settled |->
		(O_CELL_PIN_OE_N & ~io_r) == 8'h00)
		else $error("register cell not driven");
	reg_float_a: assert property (oe_high_s ##0 reg_m && settled |->
		(~O_CELL_PIN_OE_N & ~io_r) == 8'h00)
		else $error("register cell driven while disabled");
	smpl_drive_a: assert property (smpl_m && settled |->
		O_CELL_PIN_OE_N == (io_r & 8'hE7))
		else $error("simple mode drive wrong");
	reg_hold_a: assert property (clk_low_s ##0 reg_m && settled |->
		$stable(O_CELL_PIN & ~io_r))
		else $error("register moved without clock");
	pol_flip_a: assert property (clk_low_s ##0 (reg_m && settled && pol_wr && io_r == 8'h00)
		##1 (!I_CLK_PIN)[*4] |-> O_CELL_PIN ==
		($past(O_CELL_PIN, 4) ^ $past(I_PWDATA[7:0], 4) ^ $past(pol_r, 4)))
		else $error("polarity write wrong");
endmodule // pom_top_monitor
`default_nettype wire

// File: test/pom_top_test.sv
// self-checking bench for pom_top: apb tasks, pin levels, mode scenarios
// assumes pom_board on the cell pads and the monitor bound below
`timescale 1ns/1ps
`default_nettype none
module pom_top_test;
	logic I_SYS_CLK = 0, I_RST = 1, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0;
	logic I_CLK_PIN = 0, I_OE_N_PIN = 1, O_PREADY, O_PSLVERR, err;
	logic [11:0] I_PADDR = 12'h000, I_DIN = 12'h000;
	logic [31:0] I_PWDATA = 32'h0000_0000, O_PRDATA, rd;
	logic [7:0] drv_en = 8'h00, drv_val = 8'h00, pad, O_CELL_PIN, O_CELL_PIN_OE_N;
	int mismatches = 0, cmp_count = 0, cycles = 0;
	pom_top dut (.I_SYS_CLK, .I_RST, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA,
		.O_PRDATA, .O_PREADY, .O_PSLVERR, .I_DIN, .I_CLK_PIN, .I_OE_N_PIN,
		.I_CELL_PIN(pad), .O_CELL_PIN, .O_CELL_PIN_OE_N);
	pom_board board (.i_drv_en(drv_en), .i_drv_val(drv_val), .i_pin(O_CELL_PIN),
		.i_pin_oe_n(O_CELL_PIN_OE_N), .o_pad(pad));
	initial forever #12.5 I_SYS_CLK = ~I_SYS_CLK;
	always @(posedge I_SYS_CLK)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			mismatches++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check({24'h00_0000, got}, {24'h00_0000, exp});
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge I_SYS_CLK);
		I_PSEL <= 1'b1;
		I_PENABLE <= 1'b0;
		I_PWRITE <= w;
		I_PADDR <= a;
		I_PWDATA <= d;
		@(posedge I_SYS_CLK);
		I_PENABLE <= 1'b1;
		do
			@(posedge I_SYS_CLK);
		while (O_PREADY !== 1'b1);
		rd = O_PRDATA;
		err = O_PSLVERR;
		I_PSEL <= 1'b0;
		I_PENABLE <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask
	// term t lives at 0x200 + 8*t: true mask word, then complement word
	task automatic term(input logic [5:0] t, input logic [31:0] tm);
		apb(1'b1, {3'h1, t, 3'h0}, tm);
		apb(1'b1, {3'h1, t, 3'h4}, 32'h0000_0000);
	endtask
	task automatic settle();
		repeat (8) @(posedge I_SYS_CLK);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge I_SYS_CLK);
		I_RST <= 1'b0;
		rchk(12'h000, 32'h0000_0000);
		rchk(12'h008, 32'h0000_0000);
		rchk(12'h018, 32'h0000_0000);
		check(32'(err), 32'h0000_0001);
		apb(1'b1, 12'h00C, 32'h0000_00FF);
		check(32'(err), 32'h0000_0001);
		term(6'd0, 32'h8000_0001);
		term(6'd43, 32'h8000_0001);
		I_DIN <= 12'h001;
		I_OE_N_PIN <= 1'b0;
		settle();
		chk8(O_CELL_PIN_OE_N, 8'h00);
		chk8(O_CELL_PIN, 8'h00);
		I_CLK_PIN <= 1'b1;
		repeat (4) @(posedge I_SYS_CLK);
		I_CLK_PIN <= 1'b0;
		settle();
		chk8(O_CELL_PIN, 8'h21);
		rchk(12'h014, 32'h0000_0021);
		rchk(12'h00C, 32'h0000_0021);
		rchk(12'h010, 32'h0000_0121);
		rchk(12'h200, 32'h8000_0001);
		apb(1'b1, 12'h004, 32'h0000_0001);
		I_OE_N_PIN <= 1'b1;
		settle();
		chk8(O_CELL_PIN, 8'h20);
		chk8(O_CELL_PIN_OE_N, 8'hFF);
		// registered I/O cells 0 and 6; cell 5 pad pulled low to expose its feedback
		apb(1'b1, 12'h008, 32'h0000_0041);
		term(6'd7, 32'h8000_0002);
		term(6'd48, 32'h8000_0000);
		term(6'd49, 32'h8002_0000);
		drv_en <= 8'h20;
		settle();
		chk8(O_CELL_PIN, 8'h61);
		chk8(O_CELL_PIN_OE_N, 8'hBE);
		I_DIN <= 12'h002;
		settle();
		chk8(O_CELL_PIN, 8'h60);
		chk8(O_CELL_PIN_OE_N, 8'hBF);
		// complex: clock pin feeds column 0, enable pin column 7
		I_DIN <= 12'h000;
		drv_en <= 8'h80;
		apb(1'b1, 12'h000, 32'h0000_0003);
		apb(1'b1, 12'h004, 32'h0000_0000);
		term(6'd16, 32'h8000_0000);
		term(6'd17, 32'h8000_1000);
		term(6'd24, 32'h8000_0000);
		term(6'd25, 32'h8008_0000);
		rchk(12'h000, 32'h0000_0003);
		I_CLK_PIN <= 1'b1;
		I_OE_N_PIN <= 1'b0;
		settle();
		chk8(O_CELL_PIN, 8'h44);
		chk8(O_CELL_PIN_OE_N, 8'hB3);
		I_CLK_PIN <= 1'b0;
		I_OE_N_PIN <= 1'b1;
		settle();
		chk8(O_CELL_PIN, 8'h48);
		// simple: cell 0 is an input, centre cells stay outputs
		drv_en <= 8'h01;
		drv_val <= 8'h01;
		apb(1'b1, 12'h000, 32'h0000_0002);
		apb(1'b1, 12'h008, 32'h0000_0019);
		term(6'd16, 32'h8000_2000);
		term(6'd17, 32'h0000_0000);
		settle();
		chk8(O_CELL_PIN_OE_N, 8'h01);
		chk8(O_CELL_PIN, 8'h4C);
		drv_val <= 8'h00;
		settle();
		chk8(O_CELL_PIN, 8'h48);
		term(6'd23, 32'h8000_0004);
		I_DIN <= 12'h004;
		settle();
		chk8(O_CELL_PIN, 8'h4C);
		apb(1'b1, 12'h004, 32'h0000_0004);
		settle();
		chk8(O_CELL_PIN, 8'h48);
		I_RST <= 1'b1;
		repeat (4) @(posedge I_SYS_CLK);
		chk8(O_CELL_PIN_OE_N, 8'hFF);
		chk8(O_CELL_PIN, 8'h00);
		I_RST <= 1'b0;
		rchk(12'h000, 32'h0000_0000);
		close_out();
	end
endmodule // pom_top_test
bind pom_top pom_top_monitor mon (.I_SYS_CLK, .I_RST, .I_PSEL, .I_PENABLE, .I_PWRITE,
	.I_PADDR, .I_PWDATA, .O_PREADY, .O_PSLVERR, .I_CLK_PIN, .I_OE_N_PIN,
	.O_CELL_PIN, .O_CELL_PIN_OE_N);
`default_nettype wire
